// ==== hw/ipl_ctrl.v ====
/*
 Interrupt priority level registers behind an AXI4-Lite slave, with request forwarding to the CPU.
 Assumes source requests and the CPU's current level are synchronous to aclk; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "ipl_map.vh"

// Contract
// - Two 3-bit level fields for the port key inputs: low group in bits 6-4, high group in bits 2-0.
// - A 3-bit level in bits 2-0 shared by both DMA kinds, beside the timer 0/1 pair level in bits 6-4.
// - The timer 4/5 pair level sits in bits 6-4 and the timer 2/3 pair level in bits 2-0.
// - Serial channel 0 level sits in bits 6-4 and the shared 8-bit timer level in bits 2-0.
// - The converter level sits in bits 6-4 and serial channel 1 level in bits 2-0.
// - Reserved bits 7-3 of the trailing register read as zero, and software never writes ones there.
module ipl_ctrl (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [10:0] src_req,
    input wire [2:0] cpu_irq_level,
    output reg irq_req,
    output reg [2:0] irq_level,
    output reg [3:0] irq_source
);

localparam RD_IDLE = 2'b01;
localparam RD_RESP = 2'b10;

reg [2:0] lvl [0:10];
reg [10:0] src_en;
reg [31:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
reg [1:0] rd_state;
reg [1:0] next_rd_state;
wire [3:0] wr_sel;
wire [3:0] rd_sel;
wire [10:0] active;
wire [32:0] lvl_flat;
wire [2:0] best_level;
wire [3:0] best_idx;
integer k;

// Index decode: word aligned and one of the eight mapped words
function [3:0] reg_sel;
    input [31:0] a;
    begin
        if (a[1:0] != 2'h0)
            reg_sel = `IPL_SEL_NONE;
        else
        begin
            case (a[31:2])
                `IPL_IDX_PORT: reg_sel = 4'h0;
                `IPL_IDX_T16DMA: reg_sel = 4'h1;
                `IPL_IDX_T16PAIRS: reg_sel = 4'h2;
                `IPL_IDX_T8SER0: reg_sel = 4'h3;
                `IPL_IDX_SER1ADC: reg_sel = 4'h4;
                `IPL_IDX_TRAIL: reg_sel = `IPL_SEL_TRAIL;
                `IPL_IDX_ENABLE: reg_sel = `IPL_SEL_ENABLE;
                `IPL_IDX_PENDING: reg_sel = `IPL_SEL_PENDING;
                default: reg_sel = `IPL_SEL_NONE;
            endcase
        end
    end
endfunction

// Read value of a pair register: upper field, reserved zero, lower field
function [31:0] pair_word;
    input [2:0] hi;
    input [2:0] lo;
    begin
        pair_word = {24'h000000, 1'b0, hi, 1'b0, lo};
    end
endfunction

assign wr_sel = reg_sel(aw_addr);
assign rd_sel = reg_sel(s_axi_araddr);

// Address and data taken in either order; both blocked while a response waits
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
assign s_axi_arready = (rd_state == RD_IDLE);

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_held <= 1'b0;
        aw_addr <= 32'h00000000;
        w_held <= 1'b0;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `IPL_RESP_OKAY;
        src_en <= `IPL_EN_RST;
        for (k = 0; k < `IPL_NUM_SRC; k = k + 1)
            lvl[k] <= `IPL_LVL_RST;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (aw_held && w_held)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == `IPL_SEL_NONE || wr_sel == `IPL_SEL_PENDING) ?
                           `IPL_RESP_SLVERR : `IPL_RESP_OKAY;
            // Level fields live in byte 0, enable bits 10-8 in byte 1; reserved bits are dropped, never stored
            if (w_strb[0])
            begin
                case (wr_sel)
                    4'h0:
                    begin
                        lvl[0] <= w_data[`IPL_HI_MSB:`IPL_HI_LSB];
                        lvl[1] <= w_data[`IPL_LO_MSB:`IPL_LO_LSB];
                    end
                    4'h1:
                    begin
                        lvl[2] <= w_data[`IPL_HI_MSB:`IPL_HI_LSB];
                        lvl[3] <= w_data[`IPL_LO_MSB:`IPL_LO_LSB];
                    end
                    4'h2:
                    begin
                        lvl[4] <= w_data[`IPL_HI_MSB:`IPL_HI_LSB];
                        lvl[5] <= w_data[`IPL_LO_MSB:`IPL_LO_LSB];
                    end
                    4'h3:
                    begin
                        lvl[6] <= w_data[`IPL_HI_MSB:`IPL_HI_LSB];
                        lvl[7] <= w_data[`IPL_LO_MSB:`IPL_LO_LSB];
                    end
                    4'h4:
                    begin
                        lvl[8] <= w_data[`IPL_HI_MSB:`IPL_HI_LSB];
                        lvl[9] <= w_data[`IPL_LO_MSB:`IPL_LO_LSB];
                    end
                    `IPL_SEL_TRAIL: lvl[10] <= w_data[`IPL_LO_MSB:`IPL_LO_LSB];
                    `IPL_SEL_ENABLE: src_en[7:0] <= w_data[7:0];
                    default: src_en <= src_en;
                endcase
            end
            if (w_strb[1] && wr_sel == `IPL_SEL_ENABLE)
                src_en[10:8] <= w_data[10:8];
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
end

always @*
begin
    case (rd_state)
        RD_IDLE: next_rd_state = s_axi_arvalid ? RD_RESP : RD_IDLE;
        RD_RESP: next_rd_state = s_axi_rready ? RD_IDLE : RD_RESP;
        default: next_rd_state = RD_IDLE;
    endcase
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        rd_state <= RD_IDLE;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `IPL_RESP_OKAY;
    end
    else
    begin
        rd_state <= next_rd_state;
        if (rd_state == RD_IDLE && s_axi_arvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (rd_sel == `IPL_SEL_NONE) ? `IPL_RESP_SLVERR : `IPL_RESP_OKAY;
            case (rd_sel)
                4'h0: s_axi_rdata <= pair_word(lvl[0], lvl[1]);
                4'h1: s_axi_rdata <= pair_word(lvl[2], lvl[3]);
                4'h2: s_axi_rdata <= pair_word(lvl[4], lvl[5]);
                4'h3: s_axi_rdata <= pair_word(lvl[6], lvl[7]);
                4'h4: s_axi_rdata <= pair_word(lvl[8], lvl[9]);
                `IPL_SEL_TRAIL: s_axi_rdata <= {29'h00000000, lvl[10]};
                `IPL_SEL_ENABLE: s_axi_rdata <= {21'h000000, src_en};
                `IPL_SEL_PENDING: s_axi_rdata <= {21'h000000, active};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end
        else if (rd_state == RD_RESP && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

// Pending and enabled sources compete; level 0 can never win
assign active = src_req & src_en;

genvar g;
generate
    for (g = 0; g < `IPL_NUM_SRC; g = g + 1)
    begin : pack
        assign lvl_flat[3*g +: 3] = lvl[g];
    end
endgenerate

ipl_max #(
    .NUM_SRC(`IPL_NUM_SRC),
    .IDX_W(4)
) u_max (
    .levels(lvl_flat),
    .active(active),
    .max_level(best_level),
    .max_idx(best_idx)
);

// Registered so the CPU sees level and source settle together with the request
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        irq_req <= 1'b0;
        irq_level <= 3'h0;
        irq_source <= 4'h0;
    end
    else
    begin
        irq_req <= (best_level > cpu_irq_level);
        irq_level <= best_level;
        irq_source <= best_idx;
    end
end

endmodule // ipl_ctrl

// ==== hw/ipl_map.vh ====
/*
 Register indices, field positions, reset values and bus answer codes for the interrupt level block.
 Assumes a 32-bit AXI4-Lite bus where each register takes one aligned word at four times its index.
*/
`ifndef IPL_MAP_VH
`define IPL_MAP_VH

// Register indices, byte address is index * 4
`define IPL_IDX_PORT 30'h00040260
`define IPL_IDX_T16DMA 30'h00040261
`define IPL_IDX_T16PAIRS 30'h00040262
`define IPL_IDX_T8SER0 30'h00040263
`define IPL_IDX_SER1ADC 30'h00040264
`define IPL_IDX_TRAIL 30'h00040265
`define IPL_IDX_ENABLE 30'h00040266
`define IPL_IDX_PENDING 30'h00040267

// Register select codes
`define IPL_SEL_TRAIL 4'h5
`define IPL_SEL_ENABLE 4'h6
`define IPL_SEL_PENDING 4'h7
`define IPL_SEL_NONE 4'hF

// Field positions inside a level register
`define IPL_HI_MSB 6
`define IPL_HI_LSB 4
`define IPL_LO_MSB 2
`define IPL_LO_LSB 0

// Counts and reset values
`define IPL_NUM_SRC 11
`define IPL_LVL_RST 3'h0
`define IPL_EN_RST 11'h000

// AXI answer codes
`define IPL_RESP_OKAY 2'h0
`define IPL_RESP_SLVERR 2'h2

`endif

// ==== hw/ipl_max.v ====
/*
 Combinational search for the highest level among the active interrupt sources.
 Assumes levels arrive packed three bits per source, source 0 in the low bits.
*/
`timescale 1ns/1ps

module ipl_max #(
    parameter NUM_SRC = 11,
    parameter IDX_W = 4
)(
    input wire [3*NUM_SRC-1:0] levels,
    input wire [NUM_SRC-1:0] active,
    output reg [2:0] max_level,
    output reg [IDX_W-1:0] max_idx
);

integer i;

always @*
begin
    max_level = 3'h0;
    max_idx = {IDX_W{1'b0}};
    // Strict compare, so the lowest source number wins a tie
    for (i = 0; i < NUM_SRC; i = i + 1)
    begin
        if (active[i] && (levels[3*i +: 3] > max_level))
        begin
            max_level = levels[3*i +: 3];
            max_idx = i[IDX_W-1:0];
        end
    end
end

endmodule // ipl_max

// ==== test/ipl_ctrl_chk.sv ====
/*
 Checker for the interrupt level block: bus answers, read-back and request forwarding.
 Assumes it is bound to ipl_ctrl.
*/
`timescale 1ns/1ps
module ipl_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire [10:0] src_req,
    input wire [2:0] cpu_irq_level,
    input wire irq_req,
    input wire [2:0] irq_level
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_go; s_axi_arvalid && s_axi_arready; endsequence
    sequence wr_go; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    // Misaligned reads answer zero, so the mask still holds for them
    lvl_spare_a: assert property (ar_go and s_axi_araddr[31:4] == 28'h0010098 |=> (s_axi_rdata & 32'hFFFFFF88) == 32'h0)
        else $error("level read shows spare bits");
    adc_spare_a: assert property (ar_go and s_axi_araddr == 32'h00100990 |=> (s_axi_rdata & 32'hFFFFFF88) == 32'h0)
        else $error("level read shows spare bits");
    trail_zero_a: assert property (ar_go and s_axi_araddr == 32'h00100994 |=> s_axi_rdata[31:3] == 29'h0)
        else $error("trailing spare bits set");
    req_gate_a: assert property (irq_req == (irq_level > $past(cpu_irq_level)))
        else $error("request not gated by level");
    idle_quiet_a: assert property (src_req == 11'h000 |=> irq_level == 3'h0 && !irq_req)
        else $error("request without source");
    r_answer_a: assert property (ar_go |=> s_axi_rvalid) else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    b_answer_a: assert property (wr_go |=> !s_axi_awready && !s_axi_wready ##[0:1] s_axi_bvalid)
        else $error("write answer late");
endmodule // ipl_chk

bind ipl_ctrl ipl_chk i_chk (.*);

// ==== test/ipl_cpu_model.sv ====
/*
 Processor model: takes a forwarded request after a set delay and raises its own level.
 Assumes the bench drives base level, delay and the return strobe.
*/
`timescale 1ns/1ps
module ipl_cpu (
    input wire aclk,
    input wire aresetn,
    input wire irq_req,
    input wire [2:0] irq_level,
    input wire [2:0] base_level,
    input wire [7:0] delay,
    input wire ret,
    output reg [2:0] cpu_irq_level,
    output reg took
);
    reg [7:0] cnt;
    always @(posedge aclk)
    begin
        if (!aresetn || ret)
        begin
            cpu_irq_level <= base_level;
            cnt <= 8'h00;
            took <= 1'b0;
        end
        else if (irq_req && irq_level > cpu_irq_level)
        begin
            cnt <= cnt + 8'h01;
            if (cnt >= delay)
            begin
                cpu_irq_level <= irq_level;
                took <= 1'b1;
            end
        end
    end
endmodule // ipl_cpu

// ==== test/interrupt_priority_levels_tb.sv ====
/*
 Bench for the interrupt level block: field layout, bus errors, forwarding.
 Assumes ipl_ctrl, the checker bind and the processor model are compiled alongside.
*/
`timescale 1ns/1ps
module interrupt_priority_levels_tb;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, got;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ret = 1'b0;
    reg [10:0] src_req = 11'h000;
    reg [7:0] delay = 8'hC8;
    reg [1:0] resp;
    wire awready, wready, bvalid, arready, rvalid, irq_req, took;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [2:0] irq_level, cpu_lvl;
    wire [3:0] irq_source;
    integer fail_count = 0, n_compared = 0, cyc = 0, k;
    ipl_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_req(src_req), .cpu_irq_level(cpu_lvl), .irq_req(irq_req),
        .irq_level(irq_level), .irq_source(irq_source));
    ipl_cpu i_cpu (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req), .irq_level(irq_level),
        .base_level(3'h0), .delay(delay), .ret(ret), .cpu_irq_level(cpu_lvl), .took(took));
    initial forever #10 aclk = ~aclk;
    task check(input [31:0] seen, input [31:0] want);
    begin
        n_compared = n_compared + 1;
        if (seen !== want)
        begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, seen, want);
        end
    end
    endtask
    // Valid and payload held until the matching ready edge
    task wr(input [31:0] a, input [31:0] d);
    begin
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(bvalid && bready))
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        resp = bresp;
        bready <= 1'b0;
    end
    endtask
    task rd(input [31:0] a);
    begin
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!(rvalid && rready))
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
    end
    endtask
    task t_fields;
    begin
        for (k = 0; k < 6; k = k + 1)
        begin
            rd(32'h00100980 + (k << 2));
            check(got, 32'h0);
            // Trailing register: ones never written into its spare bits
            wr(32'h00100980 + (k << 2), (k == 5) ? 32'h00000007 : 32'hFFFFFFFF);
            rd(32'h00100980 + (k << 2));
            check(got, (k == 5) ? 32'h07 : 32'h77);
            wr(32'h00100980 + (k << 2), (k == 5) ? 32'h00000001 : ((k + 1) << 4) | (6 - k));
            rd(32'h00100980 + (k << 2));
            check(got, (k == 5) ? 32'h01 : ((k + 1) << 4) | (6 - k));
        end
        rd(32'h00100A00);
        check(got, 32'h0);
        check({30'h0, resp}, 32'h2);
        wr(32'h0010099C, 32'h7FF);
        check({30'h0, resp}, 32'h2);
        $display("fields test done");
    end
    endtask
    // Each source alone; its level proves which field feeds it
    task t_sources;
    begin
        wr(32'h00100998, 32'h7FF);
        for (k = 0; k < 11; k = k + 1)
        begin
            src_req <= 11'h001 << k;
            repeat (2) @(posedge aclk);
            check({28'h0, irq_source}, k);
            check({29'h0, irq_level}, (k % 2 == 0 && k < 10) ? k / 2 + 1 : 6 - k / 2);
            check({31'h0, irq_req}, 32'h1);
        end
        $display("sources test done");
    end
    endtask
    task t_accept;
    begin
        delay <= 8'h02;
        ret <= 1'b1;
        src_req <= 11'h003;
        @(posedge aclk);
        ret <= 1'b0;
        for (k = 0; k < 50 && !took; k = k + 1) @(posedge aclk);
        check({29'h0, cpu_lvl}, 32'h6);
        repeat (2) @(posedge aclk);
        check({27'h0, irq_req, irq_source}, 32'h01);
        wr(32'h00100998, 32'h001);
        rd(32'h0010099C);
        check(got, 32'h001);
        check({28'h0, irq_req, irq_level}, 32'h1);
        $display("accept test done");
    end
    endtask
    task results;
    begin
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    // Ceiling well above the 150 or so cycles the tests take
    always @(posedge aclk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            fail_count = fail_count + 1;
            results;
        end
    end
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_fields;
        t_sources;
        @(posedge aclk);
        t_accept;
        results;
    end
endmodule // interrupt_priority_levels_tb
